/* File: lvds_receiver_model.sv */
// Receiver model for the serial lines: rebuilds one word per line.
// Assumes a word starts when the frame line rises and bits come MSB first.
`timescale 1ns/1ps
module lvds_receiver_model #(
   parameter int N = 16,
   parameter int W = 14
) (
   input wire logic i_link_clk, // Link clock
   input wire logic [N-1:0] i_serial_data_line, // Serial data lines
   input wire logic i_frame_line, // Frame line
   output logic [N*W-1:0] o_words, // Last words, line i at i*W
   output logic [W-1:0] o_frame_word, // Last frame word
   output int o_count // Words received
);
   logic [N*W-1:0] sh;
   logic [W-1:0] fsh;
   int bits = 0;
   int count = 0;
   assign o_count = count;
   // Sample on the falling edge, mid-bit, where the lines have settled
   always @(negedge i_link_clk) begin
      if (bits != 0 || i_frame_line) begin
         for (int i = 0; i < N; i++) begin
            sh[i*W +: W] = {sh[i*W +: W-1], i_serial_data_line[i]};
         end
         fsh = {fsh[W-2:0], i_frame_line};
         bits = bits + 1;
         if (bits == W) begin
            o_words <= sh;
            o_frame_word <= fsh;
            count <= count + 1;
            bits = 0;
         end
      end
   end
endmodule

/* File: random_seq_gen.sv */
// Pseudo-random word generator, stepped once per conversion.
// Assumes step and restart come from logic on the same clock.
`timescale 1ns/1ps
module random_seq_gen (
   input wire logic i_clk, // Conversion clock
   input wire logic i_rst, // Synchronous reset, active high
   input wire logic i_restart, // Reload the seed
   input wire logic i_step, // Advance one position
   input wire logic i_long_poly, // 1: 23-bit polynomial, 0: 9-bit
   output logic [serial_pattern_pkg::LFSR_W-1:0] o_state // Generator state
);
   import serial_pattern_pkg::*;

   logic [LFSR_W-1:0] state;
   logic [LFSR_W-1:0] next_state;
   logic fb;

   // Feedback and next state; restart beats a step
   always_comb begin
      fb = i_long_poly ? (state[TAP_LONG_A] ^ state[TAP_LONG_B])
                       : (state[TAP_SHORT_A] ^ state[TAP_SHORT_B]);
      next_state = state;
      if (i_restart) begin
         next_state = LFSR_SEED;
      end else if (i_step) begin
         next_state = {state[LFSR_W-2:0], fb};
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         state <= LFSR_SEED;
      end else begin
         state <= next_state;
      end
   end

   assign o_state = state;
endmodule

/* File: serial_output_pattern_sync.sv */
// Output word former of a multichannel converter: maps filter output to
// converter resolution and substitutes test patterns before serializing.
// Assumes an APB master on i_clk and a receiver clocked by i_link_clk.
//
// Local design decisions: the address map and the APB slave port.
`timescale 1ns/1ps
module serial_output_pattern_sync #(
   parameter int NUM_LINES = 16,
   parameter int ADC_RES = 14,
   parameter int SER_W = 14,
   parameter int HPF_W = 16,
   parameter int CUSTOM_W = 16
) (
   input wire logic i_clk, // Conversion clock
   input wire logic i_rst, // Synchronous reset, active high
   input wire logic i_link_clk, // Link clock
   input wire logic i_link_rst, // Link reset, synchronous, active high
   input wire logic i_psel, // APB select
   input wire logic i_penable, // APB enable
   input wire logic i_pwrite, // APB write
   input wire logic [serial_pattern_pkg::APB_AW-1:0] i_paddr, // APB address
   input wire logic [31:0] i_pwdata, // APB write data
   output logic [31:0] o_prdata, // APB read data
   output logic o_pready, // APB ready
   output logic o_pslverr, // APB error, unmapped address
   input wire logic i_transmit_trigger_input, // Trigger pin, asynchronous
   input wire logic i_conv_valid, // One conversion this cycle
   input wire logic [NUM_LINES*HPF_W-1:0] i_hpf_data, // Filter output per line
   output logic [NUM_LINES-1:0] o_serial_data_line, // Serial data lines
   output logic o_frame_line, // Frame line
   output logic o_output_settling // Words may be invalid
);
   import serial_pattern_pkg::*;

   localparam int RAMP_SH = SER_W - ADC_RES;
   localparam logic [SER_W-1:0] RAMP_START = {1'b1, {(SER_W-1){1'b0}}};
   localparam logic [SER_W-1:0] RAMP_STEP = {{(SER_W-1){1'b0}}, 1'b1} << RAMP_SH;

   logic [31:0] ctrl, next_ctrl;
   logic [CUSTOM_W-1:0] custom, next_custom;
   logic [2:0] line_sel [NUM_LINES];
   logic [2:0] next_line_sel [NUM_LINES];
   logic [31:0] prdata, next_prdata, rd_word, lsel_lo, lsel_hi;
   logic acc, addr_ok, wr_en;
   logic trig_s1, trig_s2, trig_s3, soft_q;
   logic trig_edge, soft_fall, restart;
   logic [SER_W-1:0] ramp, next_ramp;
   logic tog, next_tog;
   logic [2:0] settle, next_settle;
   logic [LFSR_W-1:0] lfsr;
   logic prbs_on;
   logic [SER_W-1:0] prbs_word, deskew_w, sync_w;
   logic [NUM_LINES*SER_W-1:0] line_word, words, next_words;
   logic [SER_W-1:0] frame_word, frame_q, next_frame_q;
   logic req, next_req, ack_s1, ack_s2, ack_raw, idle, conv_ok;

   // APB decode; the slave never inserts wait states
   always_comb begin
      acc = i_psel && i_penable;
      addr_ok = (i_paddr == ADDR_CTRL) || (i_paddr == ADDR_CUSTOM) ||
                (i_paddr == ADDR_LSEL_LO) || (i_paddr == ADDR_LSEL_HI) ||
                (i_paddr == ADDR_STATUS);
      wr_en = acc && i_pwrite && addr_ok;
   end
   assign o_pready = 1'b1;
   assign o_pslverr = acc && !addr_ok;

   // Read mux; line selects are packed eight to a word
   always_comb begin
      lsel_lo = '0;
      lsel_hi = '0;
      for (int i = 0; i < NUM_LINES; i++) begin
         if (i < LSEL_PER_REG) begin
            lsel_lo[3*(i%LSEL_PER_REG) +: 3] = line_sel[i];
         end else begin
            lsel_hi[3*(i%LSEL_PER_REG) +: 3] = line_sel[i];
         end
      end
      rd_word = '0;
      case (i_paddr)
         ADDR_CTRL: rd_word = ctrl;
         ADDR_CUSTOM: rd_word[CUSTOM_W-1:0] = custom;
         ADDR_LSEL_LO: rd_word = lsel_lo;
         ADDR_LSEL_HI: rd_word = lsel_hi;
         ADDR_STATUS: begin
            rd_word[STAT_SETTLE] = o_output_settling;
            rd_word[STAT_BUSY] = !idle;
            rd_word[STAT_RAMP +: SER_W] = ramp;
         end
         default: rd_word = '0;
      endcase
   end

   // Register writes; read data is latched in the setup phase
   always_comb begin
      next_ctrl = ctrl;
      next_custom = custom;
      next_line_sel = line_sel;
      if (wr_en && i_paddr == ADDR_CTRL) begin
         next_ctrl = i_pwdata & CTRL_WMASK;
      end
      if (wr_en && i_paddr == ADDR_CUSTOM) begin
         next_custom = i_pwdata[CUSTOM_W-1:0];
      end
      for (int i = 0; i < NUM_LINES; i++) begin
         if (wr_en && i_paddr == ((i < LSEL_PER_REG) ? ADDR_LSEL_LO : ADDR_LSEL_HI)) begin
            next_line_sel[i] = i_pwdata[3*(i%LSEL_PER_REG) +: 3];
         end
      end
      next_prdata = (i_psel && !i_penable) ? rd_word : prdata;
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         ctrl <= CTRL_RESET;
         custom <= CUSTOM_RESET[CUSTOM_W-1:0];
         prdata <= '0;
         for (int i = 0; i < NUM_LINES; i++) begin
            line_sel[i] <= LSEL_RESET;
         end
      end else begin
         ctrl <= next_ctrl;
         custom <= next_custom;
         prdata <= next_prdata;
         line_sel <= next_line_sel;
      end
   end
   assign o_prdata = prdata;

   // Trigger pin passes two flops, the third finds the rising edge
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         trig_s1 <= 1'b0;
         trig_s2 <= 1'b0;
         trig_s3 <= 1'b0;
         soft_q <= 1'b0;
      end else begin
         trig_s1 <= i_transmit_trigger_input;
         trig_s2 <= trig_s1;
         trig_s3 <= trig_s2;
         soft_q <= ctrl[CTRL_SOFT_SYNC];
      end
   end

   // Restart on a pin edge unless masked, or when the soft bit is cleared
   always_comb begin
      trig_edge = trig_s2 && !trig_s3;
      soft_fall = soft_q && !ctrl[CTRL_SOFT_SYNC];
      restart = (trig_edge && !ctrl[CTRL_MASK]) || soft_fall;
   end

   // Ramp and toggle advance once per conversion; settle counter counts down every clock
   always_comb begin
      next_ramp = ramp;
      next_tog = tog;
      next_settle = (settle != 3'h0) ? settle - 3'h1 : settle;
      if (restart) begin
         next_ramp = RAMP_START;
         next_tog = 1'b0;
         next_settle = SETTLE_CLKS;
      end else if (i_conv_valid) begin
         next_ramp = ramp + RAMP_STEP;
         next_tog = !tog;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         ramp <= RAMP_START;
         tog <= 1'b0;
         settle <= 3'h0;
      end else begin
         ramp <= next_ramp;
         tog <= next_tog;
         settle <= next_settle;
      end
   end
   assign o_output_settling = (settle != 3'h0);

   // The generator holds still unless enabled, so its phase is repeatable
   random_seq_gen u_rseq (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_restart(restart || ctrl[CTRL_RSEQ_RST]),
      .i_step(i_conv_valid && ctrl[CTRL_RSEQ_EN]),
      .i_long_poly(ctrl[CTRL_RSEQ_POLY]),
      .o_state(lfsr)
   );
   assign prbs_on = ctrl[CTRL_RSEQ_SEL] && ctrl[CTRL_RSEQ_EN];
   assign prbs_word = lfsr[SER_W-1:0];

   // Fixed words: deskew starts with zero at the MSB, sync is half ones
   for (genvar b = 0; b < SER_W; b++) begin : g_fixed
      assign deskew_w[b] = ((SER_W - 1 - b) % 2) != 0;
      assign sync_w[b] = (b >= SER_W / 2);
   end

   // Pattern word for one line; the random word rides on custom or ramp
   function automatic logic [SER_W-1:0] pat_word(input logic [2:0] code,
                                                 input logic [SER_W-1:0] samp,
                                                 input logic allow_prbs);
      case (pattern_t'(code))
         PAT_NORMAL: pat_word = samp;
         PAT_ZEROS: pat_word = '0;
         PAT_ONES: pat_word = '1;
         PAT_DESKEW: pat_word = deskew_w;
         PAT_SYNC: pat_word = sync_w;
         PAT_CUSTOM: pat_word = (allow_prbs && prbs_on) ? prbs_word
                                : custom[CUSTOM_W-1 -: SER_W];
         PAT_RAMP: pat_word = (allow_prbs && prbs_on) ? prbs_word : ramp;
         PAT_TOGGLE: pat_word = {SER_W{tog}};
         default: pat_word = samp;
      endcase
   endfunction

   // Per line: resolution mapping, then pattern substitution
   for (genvar i = 0; i < NUM_LINES; i++) begin : g_line
      logic [HPF_W-1:0] hpf;
      logic [ADC_RES-1:0] trunc, adc;
      logic [ADC_RES:0] sum;
      logic rnd_en;
      logic [2:0] code;
      logic [SER_W-1:0] samp, pw;
      assign hpf = i_hpf_data[i*HPF_W +: HPF_W];
      assign trunc = hpf[HPF_W-1 -: ADC_RES];
      assign sum = {trunc[ADC_RES-1], trunc} + {{ADC_RES{1'b0}}, hpf[HPF_W-ADC_RES-1]};
      assign rnd_en = (i < GROUP_A_LINES) ? ctrl[CTRL_RND_A] : ctrl[CTRL_RND_B];
      // Rounding saturates at positive full scale instead of wrapping
      assign adc = !rnd_en ? trunc :
                   (sum[ADC_RES] != sum[ADC_RES-1]) ? {1'b0, {(ADC_RES-1){1'b1}}}
                   : sum[ADC_RES-1:0];
      // A process, so the pattern state read inside the function wakes it
      always_comb begin
         samp = '0;
         samp[SER_W-1 -: ADC_RES] = adc;
         pw = pat_word(code, samp, 1'b1);
      end
      assign code = ctrl[CTRL_LINE_EN] ? line_sel[i] : ctrl[CTRL_GSEL +: 3];
      assign line_word[i*SER_W +: SER_W] = pw;
   end
   // Frame line idles on the sync word and never carries the random word
   always_comb frame_word = pat_word(ctrl[CTRL_FSEL +: 3], sync_w, 1'b0);

   // Ack from the link domain, two flops before use
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         ack_s1 <= 1'b0;
         ack_s2 <= 1'b0;
      end else begin
         ack_s1 <= ack_raw;
         ack_s2 <= ack_s1;
      end
   end

   // Words are captured only while the link is idle; others are dropped
   always_comb begin
      idle = (req == ack_s2);
      conv_ok = i_conv_valid && idle;
      next_req = req;
      next_words = words;
      next_frame_q = frame_q;
      if (conv_ok) begin
         next_req = !req;
         next_words = line_word;
         next_frame_q = frame_word;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         req <= 1'b0;
         words <= '0;
         frame_q <= '0;
      end else begin
         req <= next_req;
         words <= next_words;
         frame_q <= next_frame_q;
      end
   end

   word_serializer #(
      .NUM_LINES(NUM_LINES),
      .SER_W(SER_W)
   ) u_ser (
      .i_link_clk(i_link_clk),
      .i_link_rst(i_link_rst),
      .i_req_toggle(req),
      .i_words(words),
      .i_frame_word(frame_q),
      .o_ack_toggle(ack_raw),
      .o_serial_data_line(o_serial_data_line),
      .o_frame_line(o_frame_line)
   );

   // Checks on the conversion clock
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);

   sequence s_restart_quiet;
      restart ##1 !restart [*6];
   endsequence

   property p_trunc;
      conv_ok && !ctrl[CTRL_LINE_EN] && ctrl[CTRL_GSEL +: 3] == PAT_NORMAL &&
      !ctrl[CTRL_RND_A] |=> words[SER_W-1 -: ADC_RES] == $past(i_hpf_data[HPF_W-1 -: ADC_RES]);
   endproperty
   a_trunc: assert property (p_trunc) else $error("truncated word mismatch");

   property p_soft;
      $fell(ctrl[CTRL_SOFT_SYNC]) |=> ramp == RAMP_START && !tog;
   endproperty
   a_soft: assert property (p_soft) else $error("soft sync did not restart");

   property p_settle;
      restart |=> o_output_settling [*6];
   endproperty
   a_settle: assert property (p_settle) else $error("settle flag too short");

   property p_settle_end;
      s_restart_quiet |=> !o_output_settling;
   endproperty
   a_settle_end: assert property (p_settle_end) else $error("settle flag too long");

   property p_mask;
      trig_edge && ctrl[CTRL_MASK] && !soft_fall && !o_output_settling
      |=> !o_output_settling;
   endproperty
   a_mask: assert property (p_mask) else $error("masked trigger disturbed ramp");

   property p_ones;
      conv_ok && !ctrl[CTRL_LINE_EN] && ctrl[CTRL_GSEL +: 3] == PAT_ONES |=> &words;
   endproperty
   a_ones: assert property (p_ones) else $error("global ones not on all lines");

   property p_zeros;
      conv_ok && !ctrl[CTRL_LINE_EN] && ctrl[CTRL_GSEL +: 3] == PAT_ZEROS |=> words == '0;
   endproperty
   a_zeros: assert property (p_zeros) else $error("global zeros not on all lines");

   property p_line_sync;
      conv_ok && ctrl[CTRL_LINE_EN] && line_sel[0] == PAT_SYNC
      |=> words[SER_W-1:0] == sync_w;
   endproperty
   a_line_sync: assert property (p_line_sync) else $error("line sync word wrong");

   property p_ramp;
      i_conv_valid && !restart |=> ramp == $past(ramp) + RAMP_STEP;
   endproperty
   a_ramp: assert property (p_ramp) else $error("ramp step wrong");

   property p_toggle;
      i_conv_valid && !restart |=> tog != $past(tog);
   endproperty
   a_toggle: assert property (p_toggle) else $error("toggle did not alternate");

   property p_rseq_rst;
      ctrl[CTRL_RSEQ_RST] |=> lfsr == LFSR_SEED;
   endproperty
   a_rseq_rst: assert property (p_rseq_rst) else $error("random restart failed");

   property p_frame;
      conv_ok && ctrl[CTRL_FSEL +: 3] == PAT_ONES |=> &frame_q;
   endproperty
   a_frame: assert property (p_frame) else $error("frame pattern wrong");

   property p_one_edge;
      trig_edge |=> !trig_edge;
   endproperty
   a_one_edge: assert property (p_one_edge) else $error("double trigger edge");
endmodule

/* File: serial_pattern_pkg.sv */
// Shared constants for the serial output pattern block: register map,
// field positions, reset values, pattern codes and serializer states.
// Assumes a 32-bit APB register bus and a separate link clock domain.
package serial_pattern_pkg;
   localparam int APB_AW = 8;
   // Register byte addresses
   localparam logic [APB_AW-1:0] ADDR_CTRL = 8'h00;
   localparam logic [APB_AW-1:0] ADDR_CUSTOM = 8'h04;
   localparam logic [APB_AW-1:0] ADDR_LSEL_LO = 8'h08;
   localparam logic [APB_AW-1:0] ADDR_LSEL_HI = 8'h0c;
   localparam logic [APB_AW-1:0] ADDR_STATUS = 8'h10;
   // Control register fields
   localparam int CTRL_GSEL = 0;
   localparam int CTRL_LINE_EN = 3;
   localparam int CTRL_FSEL = 4;
   localparam int CTRL_RND_A = 7;
   localparam int CTRL_RND_B = 8;
   localparam int CTRL_MASK = 9;
   localparam int CTRL_SOFT_SYNC = 10;
   localparam int CTRL_RSEQ_SEL = 11;
   localparam int CTRL_RSEQ_EN = 12;
   localparam int CTRL_RSEQ_POLY = 13;
   localparam int CTRL_RSEQ_RST = 14;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   localparam logic [31:0] CTRL_WMASK = 32'h0000_7fff;
   localparam logic [31:0] CUSTOM_RESET = 32'h0000_0000;
   localparam logic [2:0] LSEL_RESET = 3'h0;
   // Status register fields
   localparam int STAT_SETTLE = 0;
   localparam int STAT_BUSY = 1;
   localparam int STAT_RAMP = 16;
   // Line grouping
   localparam int GROUP_A_LINES = 8;
   localparam int LSEL_PER_REG = 8;
   // Conversion clocks flagged after a restart
   localparam logic [2:0] SETTLE_CLKS = 3'h6;
   // Pseudo-random generator
   localparam int LFSR_W = 23;
   localparam logic [22:0] LFSR_SEED = 23'h7fffff;
   localparam int TAP_LONG_A = 22;
   localparam int TAP_LONG_B = 17;
   localparam int TAP_SHORT_A = 8;
   localparam int TAP_SHORT_B = 4;
   typedef enum logic [2:0] {
      PAT_NORMAL = 3'h0,
      PAT_ZEROS = 3'h1,
      PAT_ONES = 3'h2,
      PAT_DESKEW = 3'h3,
      PAT_SYNC = 3'h4,
      PAT_CUSTOM = 3'h5,
      PAT_RAMP = 3'h6,
      PAT_TOGGLE = 3'h7
   } pattern_t;
   typedef enum logic [1:0] {
      SER_IDLE = 2'b01,
      SER_SHIFT = 2'b10
   } ser_state_t;
endpackage

/* File: testbench.sv */
// Self-checking bench for the serial output pattern block.
// Assumes the receiver model frames words on the frame line sync word.
`timescale 1ns/1ps
module testbench;
   import serial_pattern_pkg::*;
   logic i_clk = 0, i_link_clk = 0, i_rst = 1, i_link_rst = 1;
   logic psel = 0, penable = 0, pwrite = 0, trig = 0, conv = 0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, settling, frame, err_seen;
   logic [15:0] lines;
   logic [255:0] hpf = '0;
   logic [223:0] words;
   logic [13:0] fword;
   int rcount, errors = 0, n_tests = 0, cycles = 0;
   // Link clock runs free, unrelated in phase to the core clock
   always #5 i_clk = ~i_clk;
   always #16 i_link_clk = ~i_link_clk;
   serial_output_pattern_sync u_serial_output_pattern_sync (.i_clk(i_clk), .i_rst(i_rst),
      .i_link_clk(i_link_clk), .i_link_rst(i_link_rst), .i_psel(psel), .i_penable(penable),
      .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
      .o_pready(pready), .o_pslverr(pslverr), .i_transmit_trigger_input(trig),
      .i_conv_valid(conv), .i_hpf_data(hpf), .o_serial_data_line(lines),
      .o_frame_line(frame), .o_output_settling(settling));
   lvds_receiver_model u_lvds_receiver_model (.i_link_clk(i_link_clk),
      .i_serial_data_line(lines), .i_frame_line(frame), .o_words(words),
      .o_frame_word(fword), .o_count(rcount));
   task automatic close_out();
      $display("Compares %0d, mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk_word(input logic [13:0] got, input logic [13:0] exp);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH %0t word %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH %0t value %h expected %h", $time, got, exp);
      end
   endtask
   // One APB transfer; held until pready is seen in the access phase
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge i_clk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge i_clk);
      penable <= 1;
      do @(posedge i_clk); while (pready !== 1'b1);
      rd = prdata;
      err_seen = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   // One conversion, then wait for its words and for the link to go idle
   task automatic cnv();
      int n;
      n = rcount;
      @(posedge i_clk) conv <= 1;
      @(posedge i_clk) conv <= 0;
      while (rcount == n) @(posedge i_clk);
      repeat (10) @(posedge i_clk);
   endtask
   task automatic t_regs();
      apb(0, ADDR_CTRL, 32'h0);
      chk_reg(rd, CTRL_RESET);
      apb(1, ADDR_CTRL, 32'hffff_0180);
      apb(0, ADDR_CTRL, 32'h0);
      chk_reg(rd, 32'h0000_0180);
      apb(0, 8'h40, 32'h0);
      chk_reg({rd[30:0], err_seen}, 32'h1);
   endtask
   task automatic t_pat();
      logic [13:0] exp [1:5] = '{14'h0000, 14'h3fff, 14'h1555, 14'h3f80, 14'h32d7};
      apb(1, ADDR_CUSTOM, 32'h0000_cb5c);
      for (int c = 1; c < 6; c++) begin
         apb(1, ADDR_CTRL, 32'(c));
         cnv();
         chk_word(words[13:0], exp[c]);
         chk_word(words[223:210], exp[c]);
      end
      chk_word(fword, 14'h3f80);
   endtask
   task automatic t_line();
      apb(1, ADDR_CTRL, 32'h9);
      apb(1, ADDR_LSEL_LO, 32'h4);
      apb(1, ADDR_LSEL_HI, 32'h0060_0000);
      cnv();
      chk_word(words[13:0], 14'h3f80);
      chk_word(words[223:210], 14'h1555);
   endtask
   task automatic t_round();
      hpf <= {16{16'h0006}};
      apb(1, ADDR_CTRL, 32'h80);
      cnv();
      chk_word(words[13:0], 14'h0002);
      chk_word(words[223:210], 14'h0001);
      apb(1, ADDR_CTRL, 32'h0);
      cnv();
      chk_word(words[13:0], 14'h0001);
   endtask
   // Pin held high over two conversions must restart only once
   task automatic t_trig();
      apb(1, ADDR_CTRL, 32'h6);
      @(posedge i_clk) trig <= 1;
      repeat (5) @(posedge i_clk);
      chk_reg({31'h0, settling}, 32'h1);
      repeat (10) @(posedge i_clk);
      cnv();
      chk_word(words[13:0], 14'h2000);
      cnv();
      chk_word(words[13:0], 14'h2001);
      @(posedge i_clk) trig <= 0;
      chk_reg({31'h0, settling}, 32'h0);
      apb(1, ADDR_CTRL, 32'h606);
      apb(1, ADDR_CTRL, 32'h206);
      cnv();
      chk_word(words[13:0], 14'h2000);
      @(posedge i_clk) trig <= 1;
      repeat (3) @(posedge i_clk);
      trig <= 0;
      repeat (10) @(posedge i_clk);
      cnv();
      chk_word(words[13:0], 14'h2001);
      apb(1, ADDR_CTRL, 32'h407);
      apb(1, ADDR_CTRL, 32'h7);
      cnv();
      chk_word(words[13:0], 14'h0000);
      cnv();
      chk_word(words[13:0], 14'h3fff);
   endtask
   // Random word on the custom code steps per conversion; restart bit reseeds
   task automatic t_rseq();
      apb(1, ADDR_CTRL, 32'h1825);
      cnv();
      chk_word(words[13:0], 14'h3fff);
      chk_word(fword, 14'h3fff);
      cnv();
      chk_word(words[13:0], 14'h3ffe);
      apb(1, ADDR_CTRL, 32'h5825);
      apb(1, ADDR_CTRL, 32'h1825);
      cnv();
      chk_word(words[13:0], 14'h3fff);
   endtask
   // Cut a hang short
   always @(posedge i_clk) begin
      cycles++;
      if (cycles == 20000) begin
         errors++;
         close_out();
      end
   end
   initial begin
      repeat (20) @(posedge i_clk);
      i_rst <= 0;
      @(posedge i_link_clk) i_link_rst <= 0;
      t_regs();
      t_pat();
      t_line();
      t_round();
      t_trig();
      t_rseq();
      close_out();
   end
endmodule

/* File: word_serializer.sv */
// Link-side serializer: takes one word per line plus the frame word
// through a toggle handshake and shifts them out MSB first.
// Assumes the words stay stable from the request toggle until the ack.
`timescale 1ns/1ps
module word_serializer #(
   parameter int NUM_LINES = 16,
   parameter int SER_W = 14
) (
   input wire logic i_link_clk, // Link clock
   input wire logic i_link_rst, // Link reset, synchronous, active high
   input wire logic i_req_toggle, // New words pending (core domain)
   input wire logic [NUM_LINES*SER_W-1:0] i_words, // Line words (core domain)
   input wire logic [SER_W-1:0] i_frame_word, // Frame word (core domain)
   output logic o_ack_toggle, // Words captured
   output logic [NUM_LINES-1:0] o_serial_data_line, // Serial data lines
   output logic o_frame_line // Frame line
);
   import serial_pattern_pkg::*;

   localparam int CW = $clog2(SER_W + 1);
   localparam logic [CW-1:0] LAST_BIT = CW'(SER_W - 1);

   ser_state_t state;
   ser_state_t next_state;
   logic req_s1, req_s2, seen, next_seen;
   logic [CW-1:0] cnt, next_cnt;
   logic [NUM_LINES:0][SER_W-1:0] sh;
   logic [NUM_LINES:0][SER_W-1:0] next_sh;

   // Two-stage synchroniser for the request toggle
   always_ff @(posedge i_link_clk) begin
      if (i_link_rst) begin
         req_s1 <= 1'b0;
         req_s2 <= 1'b0;
      end else begin
         req_s1 <= i_req_toggle;
         req_s2 <= req_s1;
      end
   end

   // Capture on a fresh toggle, then shift SER_W bits out
   always_comb begin
      next_state = state;
      next_seen = seen;
      next_cnt = cnt;
      next_sh = sh;
      case (state)
         SER_IDLE: begin
            if (req_s2 != seen) begin
               next_seen = req_s2;
               next_sh = {i_frame_word, i_words};
               next_cnt = '0;
               next_state = SER_SHIFT;
            end
         end
         SER_SHIFT: begin
            for (int k = 0; k <= NUM_LINES; k++) begin
               next_sh[k] = sh[k] << 1;
            end
            next_cnt = cnt + 1'b1;
            if (cnt == LAST_BIT) begin
               next_state = SER_IDLE;
            end
         end
         default: next_state = SER_IDLE;
      endcase
   end

   always_ff @(posedge i_link_clk) begin
      if (i_link_rst) begin
         state <= SER_IDLE;
         seen <= 1'b0;
         cnt <= '0;
         sh <= '0;
      end else begin
         state <= next_state;
         seen <= next_seen;
         cnt <= next_cnt;
         sh <= next_sh;
      end
   end

   // Every line shows its shift register MSB
   for (genvar i = 0; i < NUM_LINES; i++) begin : g_out
      assign o_serial_data_line[i] = sh[i][SER_W-1];
   end
   assign o_frame_line = sh[NUM_LINES][SER_W-1];
   assign o_ack_toggle = seen;
endmodule
